// ---- rtl/alarm_priority_encoder.sv ----
// priority encoder from ranked alarm sources to a five-bit alarm code
`timescale 1ns/1ps
`default_nettype none
`include "servo_status_params.svh"

module alarm_priority_encoder
  import servo_status_pkg::*;
#(
  parameter int N = NUM_ALARMS
) (
  input wire logic [N-1:0] alarm_i,
  output logic any_o,
  output logic [4:0] code_o
);

  if (N != NUM_ALARMS) begin : g_bad_n
    $error("alarm_priority_encoder: table holds exactly NUM_ALARMS ranks");
  end

  // index is rank minus one
  function automatic logic [4:0] rank_code(input int idx);
    unique case (idx)
      0, 1: rank_code = `CODE_OVERCURRENT;
      2: rank_code = `CODE_OVERSPEED;
      3, 16: rank_code = `CODE_UNDERVOLT;
      4: rank_code = `CODE_OVERVOLT;
      5, 6: rank_code = `CODE_ENC_TROUBLE;
      7: rank_code = `CODE_CIRCUIT;
      8: rank_code = `CODE_MEMORY;
      9: rank_code = `CODE_FUSE;
      10: rank_code = `CODE_MOTOR_MISMATCH;
      11: rank_code = `CODE_BRAKE_TR_HEAT;
      12: rank_code = `CODE_ENC_COMM;
      13: rank_code = `CODE_CTRL_INPUT;
      14, 15: rank_code = `CODE_OVERLOAD;
      17, 18, 19: rank_code = `CODE_BRAKE_RES;
      20: rank_code = `CODE_DEVIATION;
      21: rank_code = `CODE_AMP_HEAT;
      22: rank_code = `CODE_ENC_HEAT;
      23, 24, 25: rank_code = `CODE_ABS_LOST;
      26: rank_code = `CODE_MULTITURN;
      27: rank_code = `CODE_INIT_ERR;
      28: rank_code = `CODE_PULSE_FREQ;
      default: rank_code = `CODE_NONE;
    endcase
  endfunction

  // walk from the worst rank upward so the best rank is written last
  always_comb begin
    code_o = `CODE_NONE;
    any_o = |alarm_i;
    for (int i = N - 1; i >= 0; i--) begin
      if (alarm_i[i]) begin
        code_o = rank_code(i); // [RULE8] [RULE9] [RULE10] [RULE12]
      end
    end
  end

endmodule // alarm_priority_encoder

`default_nettype wire

// ---- rtl/servo_status_alarm_encoder.sv ----
// servo amplifier status flags and alarm code with a wishbone register port
// Overview of operation
// RULE1: data error rises when a host read or write carries an out-of-limit value.
// RULE2: data error clears once the host drops its read or overwrite command.
// RULE3: data error sits at a fixed process image position, no assignment needed.
// RULE4: address error on out-of-range number or negative sign at start or access.
// RULE5: address error exists only in the positioning variant, else held low.
// RULE6: five alarm code bits together identify the active alarm.
// RULE7: positioning variant presents all five code bits as one group.
// RULE8: code 00H none, 01H overload, 02H pulse frequency, 03H amplifier heat.
// RULE9: codes 04H to 0FH for braking, deviation, current, speed, voltage, encoder, memory.
// RULE10: codes 10H to 16H for encoder link, motor, transistor heat, input, absolute data.
// RULE11: warnings 17H, 18H; host transfer faults 19H to 1EH.
// RULE12: simultaneous alarms show the best ranked one; overcurrent first.
// RULE13: life warning is capacitor life or fan life exceeded.
// RULE14: over-travel detect outputs high while matching input is low.
// RULE15: software travel select at 1 permits motion only between the two limits.
// RULE16: home switch detect follows the home limit switch input.
// RULE17: forced stop detect high while the active-low forced stop input is low.
// RULE18: image forced stop on servo-on or forced stop low, or image stop bit set.
// RULE19: battery warning while battery low with absolute position system established.
// RULE20: all status and code outputs come from clocked registers.
// RULE21: after reset every status output is low and the code is 00H.
`timescale 1ns/1ps
`default_nettype none
`include "servo_status_params.svh"

module servo_status_alarm_encoder
  import servo_status_pkg::*;
#(
  parameter bit POSITIONING_VARIANT = 1'b1,
  parameter int POS_W = 32
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire pins_t pins_i,
  input wire host_req_t host_req_i,
  input wire logic image_forced_stop_i,
  input wire logic signed [POS_W-1:0] position_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output status_t status_o,
  output logic motion_permit_o
);

  if (POS_W < 2 || POS_W > 32) begin : g_bad_pos_w
    $error("servo_status_alarm_encoder: POS_W must lie in 2..32");
  end

  // reset release
  logic rst_meta_n;
  logic rst_n;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // pin synchronisers; the first stage feeds only the second
  // reset loads the idle levels, so no false over-travel or stop shows after release
  localparam pins_t PINS_IDLE = '{pos_overtravel: `PIN_LEVEL_OK,
                                  neg_overtravel: `PIN_LEVEL_OK,
                                  forced_stop_n: `PIN_LEVEL_OK,
                                  servo_on: `PIN_LEVEL_OK,
                                  default: '0};

  pins_t pins_meta;
  pins_t pins_s;
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pins_meta <= PINS_IDLE;
      pins_s <= PINS_IDLE;
    end else begin
      pins_meta <= pins_i;
      pins_s <= pins_meta;
    end
  end

  function automatic logic bcd_ok(input logic [15:0] v);
    bcd_ok = 1'b1;
    for (int d = 0; d < 4; d++) begin
      if (v[d*4 +: 4] > 4'h9) begin
        bcd_ok = 1'b0;
      end
    end
  endfunction

  function automatic logic [31:0] merge_sel(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] sel);
    for (int b = 0; b < 4; b++) begin
      merge_sel[b*8 +: 8] = sel[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction

  // registers written by software
  logic [1:0] ctrl;
  logic [31:0] pos_limit;
  logic [31:0] neg_limit;
  logic [VALUE_W-1:0] data_max;
  logic [NUMBER_W-1:0] number_max;

  logic wb_req;
  logic wb_wr;
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_req && wb_we_i;

  // one-cycle answer; the write lands on the edge that raises ack
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `RST_CTRL;
      pos_limit <= `RST_POS_LIMIT;
      neg_limit <= `RST_NEG_LIMIT;
      data_max <= `RST_DATA_MAX;
      number_max <= `RST_NUMBER_MAX;
    end else if (wb_wr) begin
      unique case (wb_adr_i)
        `REG_CTRL: ctrl <= 2'(merge_sel(32'(ctrl), wb_dat_i, wb_sel_i));
        `REG_POS_LIMIT: pos_limit <= merge_sel(pos_limit, wb_dat_i, wb_sel_i);
        `REG_NEG_LIMIT: neg_limit <= merge_sel(neg_limit, wb_dat_i, wb_sel_i);
        `REG_DATA_MAX: data_max <= VALUE_W'(merge_sel(32'(data_max), wb_dat_i, wb_sel_i));
        `REG_NUMBER_MAX: number_max <= NUMBER_W'(merge_sel(32'(number_max), wb_dat_i, wb_sel_i));
        default: ;
      endcase
    end
  end

  // unmapped and status-write accesses are acknowledged; reads return zero
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wb_dat_o <= '0;
    end else if (wb_req && !wb_we_i) begin
      unique case (wb_adr_i)
        `REG_CTRL: wb_dat_o <= 32'(ctrl);
        `REG_POS_LIMIT: wb_dat_o <= pos_limit;
        `REG_NEG_LIMIT: wb_dat_o <= neg_limit;
        `REG_DATA_MAX: wb_dat_o <= 32'(data_max);
        `REG_NUMBER_MAX: wb_dat_o <= 32'(number_max);
        `REG_STATUS: wb_dat_o <= 32'(status_o);
        default: wb_dat_o <= '0;
      endcase
    end
  end

  // host transfer checks; the host request comes from same-clock link logic
  logic data_bad;
  logic data_bcd_bad;
  logic reject;
  logic addr_access;
  logic addr_bcd_bad;
  logic addr_range_bad;
  logic addr_bad;
  logic data_error;
  logic address_error;
  logic [4:0] host_code;
  logic [4:0] next_host_code;

  assign data_bcd_bad = !bcd_ok(host_req_i.value);
  // a start arriving under a running read or overwrite is refused
  assign reject = host_req_i.rw_command && host_req_i.start;
  assign data_bad = host_req_i.rw_command &&
                    (data_bcd_bad || host_req_i.value > data_max || reject); // [RULE1]
  assign addr_access = host_req_i.rw_command || host_req_i.start;
  assign addr_bcd_bad = !bcd_ok(16'(host_req_i.number));
  assign addr_range_bad = host_req_i.number > number_max;
  assign addr_bad = addr_bcd_bad || addr_range_bad || host_req_i.negative; // [RULE4]

  // the error holds until the command drops; no clear races a set here
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      data_error <= 1'b0;
    end else begin
      data_error <= host_req_i.rw_command && (data_error || data_bad); // [RULE1] [RULE2]
    end
  end

  // re-evaluated on every access, so a correct number with no negative sign clears it
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      address_error <= 1'b0;
    end else if (!POSITIONING_VARIANT) begin
      address_error <= 1'b0; // [RULE5]
    end else if (addr_access) begin
      address_error <= addr_bad; // [RULE4]
    end
  end

  always_comb begin
    next_host_code = `CODE_NONE;
    if (addr_access && addr_bad && POSITIONING_VARIANT) begin
      if (host_req_i.negative) begin
        next_host_code = `CODE_NEG_SIGN; // [RULE11]
      end else if (addr_bcd_bad) begin
        next_host_code = `CODE_ADDR_BCD; // [RULE11]
      end else begin
        next_host_code = `CODE_ADDR_RANGE; // [RULE11]
      end
    end else if (data_bad) begin
      if (reject) begin
        next_host_code = `CODE_CMD_REJECT; // [RULE11]
      end else if (data_bcd_bad) begin
        next_host_code = `CODE_DATA_BCD; // [RULE11]
      end else begin
        next_host_code = `CODE_DATA_RANGE; // [RULE11]
      end
    end
  end

  // a fault keeps its code while its flag stands, unless a new faulty access replaces it
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      host_code <= `CODE_NONE;
    end else if (!(data_error || address_error) || host_code == `CODE_NONE ||
                 next_host_code != `CODE_NONE) begin
      host_code <= next_host_code;
    end else if (!host_req_i.rw_command && !address_error) begin
      host_code <= `CODE_NONE;
    end
  end

  // alarm code selection
  logic alarm_any;
  logic [4:0] alarm_code;
  logic battery_warn;
  logic life_warn;
  logic [4:0] next_code;

  alarm_priority_encoder #(
    .N(NUM_ALARMS)
  ) u_encoder (
    .alarm_i(pins_s.alarm),
    .any_o(alarm_any),
    .code_o(alarm_code)
  );

  assign battery_warn = ctrl[`CTRL_ABS_BIT] && pins_s.battery_low; // [RULE19]
  assign life_warn = pins_s.capacitor_life_over || pins_s.fan_life_over; // [RULE13]

  // alarms outrank host faults, which outrank the maintenance warnings
  always_comb begin
    if (alarm_any) begin
      next_code = alarm_code; // [RULE6] [RULE12]
    end else if (host_code != `CODE_NONE) begin
      next_code = host_code;
    end else if (battery_warn) begin
      next_code = `CODE_BATTERY; // [RULE11]
    end else if (life_warn) begin
      next_code = `CODE_LIFE; // [RULE11]
    end else begin
      next_code = `CODE_NONE; // [RULE8]
    end
  end

  // one register stage for the whole image, so the code never tears
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      status_o <= '0; // [RULE21]
    end else begin
      status_o.alarm_code <= next_code; // [RULE7] [RULE20]
      status_o.data_error <= data_error; // [RULE3]
      status_o.address_error <= address_error;
      status_o.pos_ot_detect <= !pins_s.pos_overtravel; // [RULE14]
      status_o.neg_ot_detect <= !pins_s.neg_overtravel; // [RULE14]
      status_o.home_switch_detect <= pins_s.home_switch; // [RULE16]
      status_o.forced_stop_detect <= !pins_s.forced_stop_n; // [RULE17]
      status_o.image_forced_stop <= !pins_s.servo_on || !pins_s.forced_stop_n ||
                                    image_forced_stop_i; // [RULE18]
      status_o.battery_warning <= battery_warn; // [RULE19]
      status_o.life_warning <= life_warn; // [RULE13]
    end
  end

  // software travel window, limits compared as signed positions
  logic signed [POS_W-1:0] pos_lim_s;
  logic signed [POS_W-1:0] neg_lim_s;
  assign pos_lim_s = POS_W'(pos_limit);
  assign neg_lim_s = POS_W'(neg_limit);

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      motion_permit_o <= 1'b0;
    end else if (ctrl[`CTRL_SOFT_SEL_BIT] == `SOFT_SEL_ON) begin
      motion_permit_o <= position_i <= pos_lim_s && position_i >= neg_lim_s; // [RULE15]
    end else begin
      motion_permit_o <= 1'b1;
    end
  end

  // checks on the host flags, the code and the status image
  chk_data_err_clear: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // [RULE2]
    !host_req_i.rw_command |=> !data_error) else $error("data error outlived command");
  chk_data_err_set: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // [RULE1]
    data_bad |=> data_error ##1 status_o.data_error) else $error("data error missed");
  chk_addr_err_set: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // [RULE4]
    addr_access && host_req_i.negative |=> address_error == POSITIONING_VARIANT)
    else $error("address error wrong");
  chk_addr_absent: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // [RULE5]
    !POSITIONING_VARIANT |-> !status_o.address_error) else $error("address error present");
  chk_code_alarm: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // [RULE12]
    pins_s.alarm[0] |=> status_o.alarm_code == `CODE_OVERCURRENT)
    else $error("overcurrent not first");
  chk_code_idle: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // [RULE8]
    !alarm_any && host_code == `CODE_NONE && !battery_warn && !life_warn
    |=> status_o.alarm_code == `CODE_NONE) else $error("code not idle");
  chk_code_battery: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // [RULE11]
    !alarm_any && host_code == `CODE_NONE && battery_warn
    |=> status_o.alarm_code == `CODE_BATTERY) else $error("battery code missed");
  chk_ot_follow: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // [RULE14]
    $fell(pins_s.pos_overtravel) |=> status_o.pos_ot_detect) else $error("ot detect late");
  chk_home_follow: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // [RULE16]
    pins_s.home_switch |=> status_o.home_switch_detect) else $error("home detect missed");
  chk_stop_detect: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // [RULE17]
    !pins_s.forced_stop_n |=> status_o.forced_stop_detect) else $error("stop detect missed");
  chk_forced_stop: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // [RULE18]
    image_forced_stop_i |=> status_o.image_forced_stop) else $error("image stop missed");
  chk_battery_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // [RULE19]
    !ctrl[`CTRL_ABS_BIT] |=> !status_o.battery_warning) else $error("battery warn ungated");
  chk_life_or: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // [RULE13]
    pins_s.fan_life_over |=> status_o.life_warning) else $error("life warn missed");
  chk_travel_block: assert property (@(posedge sys_clk_i) disable iff (!rst_n) // [RULE15]
    ctrl[`CTRL_SOFT_SEL_BIT] && position_i > pos_lim_s |=> !motion_permit_o)
    else $error("motion past limit");
  chk_reset_low: assert property (@(posedge sys_clk_i) // [RULE21]
    !rst_n |-> status_o == '0) else $error("status not clear in reset");

endmodule // servo_status_alarm_encoder

`default_nettype wire

// ---- rtl/servo_status_params.svh ----
// named constants for the servo status and alarm encoder
`ifndef SERVO_STATUS_PARAMS_SVH
`define SERVO_STATUS_PARAMS_SVH

// alarm codes
`define CODE_NONE           5'h00
`define CODE_OVERLOAD       5'h01
`define CODE_PULSE_FREQ     5'h02
`define CODE_AMP_HEAT       5'h03
`define CODE_BRAKE_RES      5'h04
`define CODE_DEVIATION      5'h05
`define CODE_OVERCURRENT    5'h06
`define CODE_OVERSPEED      5'h07
`define CODE_OVERVOLT       5'h08
`define CODE_UNDERVOLT      5'h09
`define CODE_ENC_TROUBLE    5'h0A
`define CODE_INIT_ERR       5'h0B
`define CODE_CIRCUIT        5'h0C
`define CODE_MEMORY         5'h0D
`define CODE_FUSE           5'h0F
`define CODE_ENC_COMM       5'h10
`define CODE_MOTOR_MISMATCH 5'h11
`define CODE_BRAKE_TR_HEAT  5'h12
`define CODE_CTRL_INPUT     5'h13
`define CODE_ENC_HEAT       5'h14
`define CODE_ABS_LOST       5'h15
`define CODE_MULTITURN      5'h16
`define CODE_BATTERY        5'h17
`define CODE_LIFE           5'h18
`define CODE_ADDR_BCD       5'h19
`define CODE_ADDR_RANGE     5'h1A
`define CODE_CMD_REJECT     5'h1B
`define CODE_DATA_BCD       5'h1C
`define CODE_DATA_RANGE     5'h1D
`define CODE_NEG_SIGN       5'h1E

// register byte offsets
`define REG_CTRL            8'h00
`define REG_POS_LIMIT       8'h04
`define REG_NEG_LIMIT       8'h08
`define REG_DATA_MAX        8'h0C
`define REG_NUMBER_MAX      8'h10
`define REG_STATUS          8'h14

// control field positions and reset values
`define CTRL_SOFT_SEL_BIT   0
`define CTRL_ABS_BIT        1
`define SOFT_SEL_ON         1'b1
`define RST_CTRL            2'h0
`define RST_POS_LIMIT       32'h7FFFFFFF
`define RST_NEG_LIMIT       32'h80000000
`define RST_DATA_MAX        16'h9999
`define RST_NUMBER_MAX      12'h063

// idle level of the travel-ok, stop-released and servo-on pins held by the synchroniser in reset
`define PIN_LEVEL_OK        1'b1

`endif

// ---- rtl/servo_status_pkg.sv ----
// types shared by the servo status and alarm encoder
package servo_status_pkg;

  localparam int NUM_ALARMS = 29;
  localparam int NUMBER_W = 12;
  localparam int VALUE_W = 16;

  // bit i of alarm is the alarm of priority rank i+1
  typedef struct packed {
    logic [NUM_ALARMS-1:0] alarm;
    logic pos_overtravel;
    logic neg_overtravel;
    logic home_switch;
    logic forced_stop_n;
    logic servo_on;
    logic battery_low;
    logic capacitor_life_over;
    logic fan_life_over;
  } pins_t;

  typedef struct packed {
    logic rw_command;
    logic start;
    logic negative;
    logic [NUMBER_W-1:0] number;
    logic [VALUE_W-1:0] value;
  } host_req_t;

  typedef struct packed {
    logic [4:0] alarm_code;
    logic data_error;
    logic address_error;
    logic pos_ot_detect;
    logic neg_ot_detect;
    logic home_switch_detect;
    logic forced_stop_detect;
    logic image_forced_stop;
    logic battery_warning;
    logic life_warning;
  } status_t;

endpackage

// ---- verif/host_plc_model.sv ----
// host controller model that drives request levels and the image stop bit
`timescale 1ns/1ps
`default_nettype none
module host_plc_model
  import servo_status_pkg::*;
(
  input wire logic clk_i,
  input wire status_t status_i,
  output var host_req_t req_o,
  output var logic image_stop_o
);
  initial begin
    req_o = '0;
    image_stop_o = 1'b0;
  end

  // one access held as a level; the status is sampled before the command drops
  task automatic access(input logic rw, input logic st, input logic neg,
      input logic [NUMBER_W-1:0] num, input logic [VALUE_W-1:0] val, output status_t seen);
    @(posedge clk_i);
    req_o <= '{rw_command: rw, start: st, negative: neg, number: num, value: val};
    repeat (4) @(posedge clk_i);
    seen = status_i;
    req_o.rw_command <= 1'b0;
    req_o.start <= 1'b0;
    req_o.negative <= 1'b0;
    // released fields show the inverse so a stale value never passes for a live one
    req_o.number <= ~num;
    req_o.value <= ~val;
  endtask

  task automatic set_image_stop(input logic v);
    @(posedge clk_i);
    image_stop_o <= v;
  endtask
endmodule // host_plc_model
`default_nettype wire

// ---- verif/tb.sv ----
// self-checking bench for the servo status and alarm encoder
`timescale 1ns/1ps
`default_nettype none
module tb
  import servo_status_pkg::*;
;
  logic sys_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  pins_t pins, nom, p;
  host_req_t req;
  logic img, ack, permit, cyc, stb, we;
  logic signed [31:0] pos = 32'sh0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, dat_o;
  status_t st, st2, seen;
  int error_cnt = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [4:0] code_tab [29] = '{5'h06, 5'h06, 5'h07, 5'h09, 5'h08, 5'h0A, 5'h0A, 5'h0C,
    5'h0D, 5'h0F, 5'h11, 5'h12, 5'h10, 5'h13, 5'h01, 5'h01, 5'h09, 5'h04, 5'h04, 5'h04,
    5'h05, 5'h03, 5'h14, 5'h15, 5'h15, 5'h15, 5'h16, 5'h0B, 5'h02};

  always #4 sys_clk_i = ~sys_clk_i;

  servo_status_alarm_encoder uut (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .pins_i(pins), .host_req_i(req),
    .image_forced_stop_i(img), .position_i(pos), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .status_o(st), .motion_permit_o(permit));
  // speed variant beside it: same stimulus, address error must stay low
  servo_status_alarm_encoder #(.POSITIONING_VARIANT(1'b0)) uut_speed (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .pins_i(pins), .host_req_i(req),
    .image_forced_stop_i(img), .position_i(pos), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(),
    .wb_ack_o(), .status_o(st2), .motion_permit_o());
  host_plc_model plc (.clk_i(sys_clk_i), .status_i(st), .req_o(req), .image_stop_o(img));

  task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
    n_compared++;
    if (seen_v !== exp_v) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen_v, exp_v);
    end
  endtask

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      error_cnt++;
      results();
    end
  end

  // classic single cycle; read data is taken at the edge that samples ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= d;
    // only the bench timeout ends a wait for an ack that never comes
    do begin
      @(posedge sys_clk_i);
    end while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // pins pass a two-flop synchroniser and an output register, so allow a margin
  task automatic settle;
    repeat (5) @(posedge sys_clk_i);
  endtask

  task automatic apply(input pins_t v);
    @(posedge sys_clk_i);
    pins <= v;
    settle();
  endtask

  task automatic t_regs;
    logic [7:0] a [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18};
    logic [31:0] e [6] = '{32'h0, 32'h7FFFFFFF, 32'h80000000, 32'h9999, 32'h63, 32'h0};
    for (int i = 0; i < 6; i++) begin
      wb(1'b0, a[i], 32'h0);
      check(rdat, e[i]);
    end
    wb(1'b1, 8'h14, 32'hFFFFFFFF);
    wb(1'b1, 8'h18, 32'hFFFFFFFF);
    wb(1'b0, 8'h14, 32'h0);
    check(rdat, 32'h0);
    wb(1'b0, 8'h18, 32'h0);
    check(rdat, 32'h0);
    $display("test registers done");
  endtask

  task automatic t_alarms;
    for (int i = 0; i < NUM_ALARMS; i++) begin
      p = nom;
      p.alarm = NUM_ALARMS'(1) << i;
      apply(p);
      check(st.alarm_code, code_tab[i]);
      p.alarm = {NUM_ALARMS{1'b1}} << i;
      apply(p);
      check(st.alarm_code, code_tab[i]);
    end
    wb(1'b0, 8'h14, 32'h0);
    check(rdat, {18'h0, 5'h02, 9'h000});
    apply(nom);
    check(st.alarm_code, 5'h00);
    $display("test alarm codes done");
  endtask

  task automatic t_pins;
    p = nom;
    p.pos_overtravel = 1'b0;
    apply(p);
    check({st.pos_ot_detect, st.neg_ot_detect}, 2'b10);
    p = nom;
    p.neg_overtravel = 1'b0;
    p.home_switch = 1'b1;
    apply(p);
    check({st.pos_ot_detect, st.neg_ot_detect, st.home_switch_detect}, 3'b011);
    p = nom;
    p.forced_stop_n = 1'b0;
    apply(p);
    check({st.forced_stop_detect, st.image_forced_stop}, 2'b11);
    p = nom;
    p.servo_on = 1'b0;
    apply(p);
    check({st.forced_stop_detect, st.image_forced_stop}, 2'b01);
    apply(nom);
    plc.set_image_stop(1'b1);
    settle();
    check({st.home_switch_detect, st.image_forced_stop}, 2'b01);
    plc.set_image_stop(1'b0);
    p = nom;
    p.battery_low = 1'b1;
    apply(p);
    check({st.battery_warning, st.alarm_code}, 6'h00);
    wb(1'b1, 8'h00, 32'h2);
    settle();
    check({st.battery_warning, st.alarm_code}, {1'b1, 5'h17});
    p.capacitor_life_over = 1'b1;
    apply(p);
    check({st.life_warning, st.alarm_code}, {1'b1, 5'h17});
    p = nom;
    p.fan_life_over = 1'b1;
    apply(p);
    check({st.life_warning, st.battery_warning, st.alarm_code}, {2'b10, 5'h18});
    apply(nom);
    check(st, '0);
    $display("test status pins done");
  endtask

  task automatic t_host;
    plc.access(1'b1, 1'b0, 1'b0, 12'h010, 16'hA000, seen);
    check({seen.data_error, seen.alarm_code}, {1'b1, 5'h1C});
    settle();
    check({st.data_error, st.alarm_code}, 6'h00);
    wb(1'b1, 8'h0C, 32'h0100);
    plc.access(1'b1, 1'b0, 1'b0, 12'h010, 16'h0200, seen);
    check({seen.data_error, seen.alarm_code}, {1'b1, 5'h1D});
    plc.access(1'b1, 1'b1, 1'b0, 12'h010, 16'h0001, seen);
    check({seen.data_error, seen.alarm_code}, {1'b1, 5'h1B});
    plc.access(1'b1, 1'b0, 1'b0, 12'h064, 16'h0001, seen);
    check({seen.address_error, seen.alarm_code}, {1'b1, 5'h1A});
    check(st2.address_error, 1'b0);
    plc.access(1'b1, 1'b0, 1'b0, 12'h0A0, 16'h0001, seen);
    check({seen.address_error, seen.alarm_code}, {1'b1, 5'h19});
    plc.access(1'b0, 1'b1, 1'b1, 12'h010, 16'h0001, seen);
    check({seen.address_error, seen.data_error, seen.alarm_code}, {2'b10, 5'h1E});
    check(st2.address_error, 1'b0);
    plc.access(1'b1, 1'b0, 1'b0, 12'h063, 16'h0001, seen);
    settle();
    check({st.address_error, st.data_error, st.alarm_code}, 7'h00);
    $display("test host transfers done");
  endtask

  task automatic t_permit;
    logic signed [31:0] v [4] = '{32'sd100, 32'sd101, -32'sd100, -32'sd101};
    logic e [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    wb(1'b1, 8'h04, 32'd100);
    wb(1'b1, 8'h08, 32'hFFFFFF9C);
    wb(1'b1, 8'h00, 32'h0);
    @(posedge sys_clk_i);
    pos <= 32'sd500;
    settle();
    check(permit, 1'b1);
    wb(1'b1, 8'h00, 32'h1);
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk_i);
      pos <= v[i];
      settle();
      check(permit, e[i]);
    end
    $display("test travel window done");
  endtask

  task automatic t_rereset;
    p = nom;
    p.alarm = NUM_ALARMS'(1);
    apply(p);
    @(posedge sys_clk_i);
    resetn_i <= 1'b0;
    @(posedge sys_clk_i);
    @(posedge sys_clk_i);
    check(st, '0);
    check(permit, 1'b0);
    // second release: the first edges after it must still show a quiet image
    @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    check(st, '0);
    settle();
    check(st.alarm_code, 5'h06);
    $display("test reset in mid-run done");
  endtask

  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    nom = '0;
    nom.pos_overtravel = 1'b1;
    nom.neg_overtravel = 1'b1;
    nom.forced_stop_n = 1'b1;
    nom.servo_on = 1'b1;
    pins = nom;
    repeat (2) @(posedge sys_clk_i);
    check(st, '0);
    check({permit, ack}, 2'b00);
    @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    t_regs();
    t_alarms();
    t_pins();
    t_host();
    t_permit();
    t_rereset();
    results();
  end
endmodule // tb
`default_nettype wire
